//--- tmr2_cfg.svh
// tmr2_cfg.svh: offsets, field positions, reset values and counts for the
// reload/capture timer. assumes inclusion by the tmr2_timer module file.
`ifndef TMR2_CFG_SVH
`define TMR2_CFG_SVH
`define TMR2_OFF_CTRL 4'h0
`define TMR2_OFF_COUNT 4'h4
`define TMR2_OFF_RELCAP 4'h8
`define TMR2_OFF_STATUS 4'hc
`define TMR2_BIT_RUN 0
`define TMR2_BIT_CAPMODE 1
`define TMR2_BIT_UPDOWN 2
`define TMR2_BIT_EXTRELOAD 3
`define TMR2_BIT_RISING 4
`define TMR2_BIT_NOPRESC 5
`define TMR2_BIT_MASK 8
`define TMR2_ST_RELOAD 0
`define TMR2_ST_CAPTURE 1
`define TMR2_CTRL_RST 32'h0000_0000
`define TMR2_ZERO16 16'h0000
`define TMR2_ONES16 16'hffff
`define TMR2_ONE16 16'h0001
`define TMR2_PRESC_DIV 12
`endif

//--- tmr2_edge_sync.sv
// tmr2_edge_sync.sv: two-flop synchroniser with edge and level outputs.
// assumes the pin is asynchronous to clk.
`timescale 1ns/1ps
module tmr2_edge_sync
(
  input wire logic clk, // clock
  input wire logic rst_n, // async reset, active low
  input wire logic ce, // clock enable
  input wire logic pinAsync, // raw pin
  output logic level, // synchronised level
  output logic rise, // one-cycle rising edge
  output logic fall // one-cycle falling edge
);
  logic meta_reg;
  logic sync_reg;
  logic prev_reg;
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      meta_reg <= 1'b0;
      sync_reg <= 1'b0;
      prev_reg <= 1'b0;
    end
    else if (ce)
    begin
      meta_reg <= pinAsync;
      sync_reg <= meta_reg;
      prev_reg <= sync_reg;
    end
  end
  assign level = sync_reg;
  // edges compare two synchronised samples, never the first stage
  assign rise = ce && sync_reg && !prev_reg; // RQ15
  assign fall = ce && !sync_reg && prev_reg; // RQ15
endmodule

//--- tmr2_pin_model.sv
// tmr2_pin_model.sv: far side of the timer, the party driving the pin.
// assumes the bench calls drive() right after a rising clk edge.
`timescale 1ns/1ps
module tmr2_pin_model
(
  input wire logic clk, // bench clock
  output logic pin // external trigger/direction pin
);
  initial pin = 1'b0;
  ////////////////////////////////////////////////////////////////////
  // lag lets the bench answer promptly or slowly; the level is held
  // until the next call, since it sets the count direction
  task automatic drive(input logic v, input int lag);
    repeat (lag) @(posedge clk);
    pin <= v;
  endtask
endmodule

//--- tmr2_pkg.sv
// tmr2_pkg.sv: types shared by the reload/capture timer files.
// assumes tmr2_cfg.svh supplies the numeric constants.
package tmr2_pkg;
  typedef struct packed {
    logic [31:0] addr;
    logic read;
    logic write;
    logic [31:0] writedata;
    logic [3:0] byteenable;
  } tmr2_avreq_t;
  typedef struct packed {
    logic [31:0] readdata;
    logic waitrequest;
  } tmr2_avrsp_t;
  typedef enum logic [2:0] {
    TMR2_IDLE = 3'b001,
    TMR2_ACK = 3'b010,
    TMR2_HOLD = 3'b100
  } tmr2_bus_st_t;
endpackage

//--- tmr2_timer.sv
// tmr2_timer.sv: 16-bit reload/capture timer with avalon-mm slave.
// assumes a synchronous bus master and an asynchronous external pin.
//
// The placing of the registers and the Avalon-MM slave port were left to the implementer.
`timescale 1ns/1ps
`include "tmr2_cfg.svh"
// What this block does
// RQ1: one 16-bit counter, either auto-reload or single-channel capture mode.
// RQ2: with the prescaler the counter steps once per twelve clocks.
// RQ3: counting never halts while enabled, whatever event occurs.
// RQ4: up-only reload mode counts from reload value, overflows at all ones.
// RQ5: up-only reload mode optionally also reloads on a selected pin edge.
// RQ6: up-only reload mode raises interrupt on every reload event.
// RQ7: in up/down mode the pin level sets the counting direction.
// RQ8: up/down mode raises no interrupt at all.
// RQ9: counting up runs reload value to all ones, then reloads it.
// RQ10: counting down from all ones underflows at reload value, reloads ones.
// RQ11: capture mode counts zero to all ones, restarting at zero.
// RQ12: capture mode triggers capture on the selected pin edge.
// RQ13: capture copies the counter into the reload/capture register.
// RQ14: capture mode interrupts on overflow reload and on capture.
// RQ15: pin is synchronised and edges found from successive samples.
module tmr2_timer
#(
  parameter int PRESC_DIV = `TMR2_PRESC_DIV
)
(
  input wire logic clk, // 100 mhz clock
  input wire logic rst_n, // async reset, active low
  input wire logic ce, // clock enable, freezes state when low
  input wire tmr2_pkg::tmr2_avreq_t avReq, // avalon request
  output tmr2_pkg::tmr2_avrsp_t avRsp, // avalon response
  input wire logic timerExtInput, // external trigger/direction pin
  output logic irq // level interrupt
);
  import tmr2_pkg::*;

  initial
  begin
    if (PRESC_DIV < 1 || PRESC_DIV > 255)
      $error("PRESC_DIV out of range");
  end

  ////////////////////////////////////////////////////////////////////////
  // pin synchroniser
  logic pinLevel;
  logic pinRise;
  logic pinFall;
  tmr2_edge_sync u_sync
  (
    .clk(clk),
    .rst_n(rst_n),
    .ce(ce),
    .pinAsync(timerExtInput),
    .level(pinLevel),
    .rise(pinRise),
    .fall(pinFall)
  );

  ////////////////////////////////////////////////////////////////////////
  // registers
  logic [31:0] ctrl_reg;
  logic [15:0] timer_count_value_reg;
  logic [15:0] reload_capture_value_reg;
  logic [1:0] status_reg;
  logic [7:0] presc_reg;
  logic [31:0] rdata_reg;
  logic wait_reg;
  logic irq_reg;
  tmr2_bus_st_t busSt_reg;

  wire run = ctrl_reg[`TMR2_BIT_RUN];
  wire capMode = ctrl_reg[`TMR2_BIT_CAPMODE]; // RQ1
  wire upDown = ctrl_reg[`TMR2_BIT_UPDOWN] && !capMode;
  wire extReload = ctrl_reg[`TMR2_BIT_EXTRELOAD];
  wire edgeRising = ctrl_reg[`TMR2_BIT_RISING];
  wire noPresc = ctrl_reg[`TMR2_BIT_NOPRESC];
  wire [1:0] irqMask = ctrl_reg[`TMR2_BIT_MASK +: 2];

  ////////////////////////////////////////////////////////////////////////
  // tick generation
  wire prescWrap = (presc_reg == 8'(PRESC_DIV - 1));
  wire tick = ce && run && (noPresc || prescWrap); // RQ2
  wire [7:0] prescNext = (!run || prescWrap) ? 8'h00 : presc_reg + 8'h01;

  ////////////////////////////////////////////////////////////////////////
  // counting
  wire pinEdge = edgeRising ? pinRise : pinFall; // RQ5 RQ12
  wire countDown = upDown && !pinLevel; // RQ7
  wire atOnes = (timer_count_value_reg == `TMR2_ONES16);
  wire atFloor = (timer_count_value_reg == reload_capture_value_reg);
  wire overflow = tick && !countDown && atOnes; // RQ4 RQ9
  wire underflow = tick && countDown && atFloor; // RQ10
  wire edgeReload = run && !capMode && !upDown && extReload && pinEdge; // RQ5
  wire captureEv = run && capMode && pinEdge; // RQ12
  wire reloadEv = overflow || underflow || edgeReload;
  // reload values per mode; capture mode restarts from zero
  wire [15:0] reloadVal = capMode ? `TMR2_ZERO16 : // RQ11
    (countDown ? `TMR2_ONES16 : reload_capture_value_reg); // RQ9 RQ10
  wire [15:0] stepVal = countDown ?
    timer_count_value_reg - `TMR2_ONE16 :
    timer_count_value_reg + `TMR2_ONE16;
  // counting continues through every event, never stopping
  wire [15:0] cntNext = reloadEv ? reloadVal :
    (tick ? stepVal : timer_count_value_reg); // RQ3

  // interrupt events; up/down mode raises none
  wire setReload = reloadEv && !upDown; // RQ6 RQ8 RQ14
  wire setCapture = captureEv; // RQ14

  ////////////////////////////////////////////////////////////////////////
  // bus decode
  wire accessReq = (avReq.read || avReq.write) && busSt_reg == TMR2_IDLE;
  wire [3:0] offs = avReq.addr[3:0];
  wire hitCtrl = (offs == `TMR2_OFF_CTRL);
  wire hitCount = (offs == `TMR2_OFF_COUNT);
  wire hitRelCap = (offs == `TMR2_OFF_RELCAP);
  wire hitStatus = (offs == `TMR2_OFF_STATUS);
  wire mapped = (avReq.addr[31:4] == 28'h0000000);
  wire wrEn = ce && accessReq && avReq.write && mapped;
  wire [31:0] beMask = {{8{avReq.byteenable[3]}}, {8{avReq.byteenable[2]}},
    {8{avReq.byteenable[1]}}, {8{avReq.byteenable[0]}}};
  wire [31:0] wMasked = avReq.writedata & beMask;
  wire [31:0] ctrlWrVal = (ctrl_reg & ~beMask) | wMasked;
  wire [31:0] readVal = !mapped ? 32'h0000_0000 :
    hitCtrl ? ctrl_reg :
    hitCount ? {16'h0000, timer_count_value_reg} :
    hitRelCap ? {16'h0000, reload_capture_value_reg} :
    hitStatus ? {30'h0000_0000, status_reg} : 32'h0000_0000;

  wire [15:0] wrHalf = ctrlWrVal[15:0];
  wire [15:0] cntWr = (timer_count_value_reg & ~beMask[15:0]) |
    wMasked[15:0];
  wire [15:0] rcWr = (reload_capture_value_reg & ~beMask[15:0]) |
    wMasked[15:0];
  // capture beats a software write in the same cycle
  wire [15:0] rcNext = captureEv ? timer_count_value_reg : // RQ13
    ((wrEn && hitRelCap) ? rcWr : reload_capture_value_reg);
  wire [15:0] cntFinal = (wrEn && hitCount) ? cntWr : cntNext;
  // set wins over write-one-to-clear
  wire [1:0] w1c = (wrEn && hitStatus) ? wMasked[1:0] : 2'b00;
  wire [1:0] stSet = {setCapture, setReload};
  wire [1:0] statusNext = (status_reg & ~w1c) | stSet;
  wire irqNext = |(statusNext & irqMask);
  wire unusedBits = ^wrHalf;

  ////////////////////////////////////////////////////////////////////////
  // bus state: one wait cycle, then acknowledge
  tmr2_bus_st_t busStNext;
  always_comb
  begin
    busStNext = busSt_reg;
    case (busSt_reg)
      TMR2_IDLE: if (avReq.read || avReq.write) busStNext = TMR2_ACK;
      TMR2_ACK: busStNext = TMR2_HOLD;
      TMR2_HOLD: busStNext = TMR2_IDLE;
      default: busStNext = TMR2_IDLE;
    endcase
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      busSt_reg <= TMR2_IDLE;
      wait_reg <= 1'b1;
      rdata_reg <= 32'h0000_0000;
    end
    else if (ce)
    begin
      busSt_reg <= busStNext;
      wait_reg <= !(busStNext == TMR2_ACK);
      if (accessReq)
        rdata_reg <= readVal;
    end
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ctrl_reg <= `TMR2_CTRL_RST;
      timer_count_value_reg <= `TMR2_ZERO16;
      reload_capture_value_reg <= `TMR2_ZERO16;
      status_reg <= 2'b00;
      presc_reg <= 8'h00;
      irq_reg <= 1'b0;
    end
    else if (ce)
    begin
      if (wrEn && hitCtrl)
        ctrl_reg <= {22'h000000, ctrlWrVal[9:0]};
      timer_count_value_reg <= cntFinal;
      reload_capture_value_reg <= rcNext;
      status_reg <= statusNext;
      presc_reg <= prescNext;
      irq_reg <= irqNext;
    end
  end

  assign avRsp.readdata = rdata_reg;
  assign avRsp.waitrequest = wait_reg;
  assign irq = irq_reg;

  ////////////////////////////////////////////////////////////////////////
  // checks
  a_tick_spacing: assert property (@(posedge clk) disable iff (!rst_n) // RQ2
    tick && !noPresc && $stable(ctrl_reg) |->
      ##1 (!tick [*8]))
    else $error("prescaled tick too soon");
  a_overflow_wrap: assert property (@(posedge clk) disable iff (!rst_n) // RQ4
    overflow && !capMode && !(wrEn && hitCount) |=>
      timer_count_value_reg == $past(reload_capture_value_reg))
    else $error("overflow did not reload");
  a_down_reload: assert property (@(posedge clk) disable iff (!rst_n) // RQ10
    underflow && !(wrEn && hitCount) |=>
      timer_count_value_reg == `TMR2_ONES16)
    else $error("underflow did not reload all ones");
  a_cap_zero: assert property (@(posedge clk) disable iff (!rst_n) // RQ11
    overflow && capMode && !(wrEn && hitCount) |=>
      timer_count_value_reg == `TMR2_ZERO16)
    else $error("capture mode did not restart at zero");
  a_capture_copy: assert property (@(posedge clk) disable iff (!rst_n) // RQ13
    captureEv && ce |=>
      reload_capture_value_reg == $past(timer_count_value_reg))
    else $error("capture value wrong");
  a_updown_quiet: assert property (@(posedge clk) disable iff (!rst_n) // RQ8
    ce && upDown && !(wrEn && hitStatus) |=>
      status_reg[`TMR2_ST_RELOAD] == $past(status_reg[`TMR2_ST_RELOAD]))
    else $error("up/down mode raised reload flag");
  a_reload_flag: assert property (@(posedge clk) disable iff (!rst_n) // RQ6
    ce && reloadEv && !upDown |=> status_reg[`TMR2_ST_RELOAD])
    else $error("reload flag missing");
  a_cap_flag: assert property (@(posedge clk) disable iff (!rst_n) // RQ14
    ce && captureEv |=> status_reg[`TMR2_ST_CAPTURE])
    else $error("capture flag missing");
  a_keeps_counting: assert property (@(posedge clk) disable iff (!rst_n) // RQ3
    tick && !reloadEv && !(wrEn && hitCount) |=>
      timer_count_value_reg != $past(timer_count_value_reg))
    else $error("counter halted");
  a_irq_level: assert property (@(posedge clk) disable iff (!rst_n)
    ce |=> irq == |($past(statusNext) & $past(irqMask)))
    else $error("irq not following status");
  // the bus answers one cycle after taking a request, for one cycle only
  a_bus_answer: assert property (@(posedge clk) disable iff (!rst_n)
    ce && accessReq |=> !wait_reg)
    else $error("bus request not acknowledged");
  a_wait_single: assert property (@(posedge clk) disable iff (!rst_n)
    ce && !wait_reg |=> wait_reg)
    else $error("waitrequest low too long");
  a_read_data: assert property (@(posedge clk) disable iff (!rst_n)
    ce && accessReq && avReq.read |=> rdata_reg == $past(readVal))
    else $error("read data not captured");
  a_stopped_still: assert property (@(posedge clk) disable iff (!rst_n) // RQ3
    ce && !run && !(wrEn && hitCount) |=>
      timer_count_value_reg == $past(timer_count_value_reg))
    else $error("stopped counter moved");
  // a low clock enable must freeze counter, flags and bus alike
  a_ce_freeze: assert property (@(posedge clk) disable iff (!rst_n)
    !ce |=> $stable(timer_count_value_reg) && $stable(status_reg) &&
      $stable(busSt_reg))
    else $error("state changed while clock enable low");
  a_presc_bound: assert property (@(posedge clk) disable iff (!rst_n) // RQ2
    presc_reg < 8'(PRESC_DIV))
    else $error("prescaler out of range");
  a_up_step: assert property (@(posedge clk) disable iff (!rst_n) // RQ4
    tick && !countDown && !reloadEv && !(wrEn && hitCount) |=>
      timer_count_value_reg ==
        $past(timer_count_value_reg) + `TMR2_ONE16)
    else $error("up count step wrong");
  a_down_step: assert property (@(posedge clk) disable iff (!rst_n) // RQ7
    tick && countDown && !reloadEv && !(wrEn && hitCount) |=>
      timer_count_value_reg ==
        $past(timer_count_value_reg) - `TMR2_ONE16)
    else $error("down count step wrong");
  a_edge_reload: assert property (@(posedge clk) disable iff (!rst_n) // RQ5
    edgeReload && !(wrEn && hitCount) |=>
      timer_count_value_reg == $past(reload_capture_value_reg))
    else $error("pin edge did not reload");
  a_clear_flag: assert property (@(posedge clk) disable iff (!rst_n)
    wrEn && hitStatus && wMasked[`TMR2_ST_RELOAD] && !setReload |=>
      !status_reg[`TMR2_ST_RELOAD])
    else $error("reload flag not cleared");
  c_ce_freeze: cover property (@(posedge clk) disable iff (!rst_n)
    !ce && run);
  c_overflow: cover property (@(posedge clk) disable iff (!rst_n) overflow);
  c_underflow: cover property (@(posedge clk) disable iff (!rst_n)
    underflow);
  c_capture: cover property (@(posedge clk) disable iff (!rst_n)
    captureEv);
  c_edge_reload: cover property (@(posedge clk) disable iff (!rst_n)
    edgeReload);
endmodule

//--- tmr2_timer_test.sv
// tmr2_timer_test.sv: self-checking bench for the reload/capture timer.
// assumes the package, the pin model and the timer are compiled first.
`timescale 1ns/1ps
module tmr2_timer_test;
  import tmr2_pkg::*;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic ce = 1'b1;
  logic pin;
  logic irq;
  tmr2_avreq_t req = '0;
  tmr2_avrsp_t rsp;
  int mismatches = 0;
  int samples_checked = 0;
  int cycles = 0;
  int s;
  int e;
  logic [31:0] q;
  always #5 clk = ~clk;
  tmr2_timer #(.PRESC_DIV(12)) i_dut (.clk(clk), .rst_n(rst_n), .ce(ce),
    .avReq(req), .avRsp(rsp), .timerExtInput(pin), .irq(irq));
  tmr2_pin_model i_pin (.clk(clk), .pin(pin));
  ////////////////////////////////////////////////////////////////////
  task automatic end_of_test;
    if (mismatches == 0 && samples_checked > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  task automatic fail(input string m);
    mismatches++;
    $display("[FAIL] %0t %s", $time, m);
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] x);
    samples_checked++;
    if (g !== x) fail($sformatf("got %h want %h", g, x));
  endtask
  // counts race the bus, so a window of legal values is compared
  task automatic rng(input logic [31:0] g, input int lo, input int hi);
    samples_checked++;
    if ($isunknown(g) || g < lo || g > hi)
      fail($sformatf("got %h want %0h..%0h", g, lo, hi));
  endtask
  task automatic bus(input logic w, input logic [31:0] a,
    input logic [31:0] d);
    int n;
    n = 0;
    req.addr <= a;
    req.read <= ~w;
    req.write <= w;
    req.writedata <= d;
    req.byteenable <= 4'hf;
    @(posedge clk);
    while (rsp.waitrequest !== 1'b0 && n < 50)
    begin
      @(posedge clk);
      n++;
    end
    if (n == 50) fail("no bus answer");
    q = rsp.readdata;
    req.read <= 1'b0;
    req.write <= 1'b0;
    @(posedge clk);
  endtask
  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask
  task automatic rd(input logic [31:0] a);
    bus(1'b0, a, 32'h0);
  endtask
  ////////////////////////////////////////////////////////////////////
  always @(posedge clk)
  begin
    cycles <= cycles + 1;
    if (cycles == 20000)
    begin
      fail("timeout");
      end_of_test;
    end
  end
  initial
  begin
    void'($urandom(32'h38ad));
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    // all registers clear, unmapped place reads zero
    for (int a = 0; a <= 32'h10; a += 4)
    begin
      rd(a);
      chk(q, 32'h0);
    end
    // prescaled counting
    wr(32'h4, 32'h0);
    wr(32'h0, 32'h1);
    e = cycles;
    repeat (120) @(posedge clk);
    wr(32'h0, 32'h0);
    e = cycles - e;
    rd(32'h4);
    rng(q, e / 12 - 2, e / 12 + 1);
    // up-only overflow reload with interrupt, mask and clear
    wr(32'h8, 32'hfff0);
    wr(32'h4, 32'hfff0);
    wr(32'h0, 32'h121);
    for (int i = 0; i < 60 && irq !== 1'b1; i++) @(posedge clk);
    chk({31'h0, irq}, 32'h1);
    rd(32'h4);
    rng(q, 32'hfff0, 32'hffff);
    wr(32'h0, 32'h20);
    repeat (3) @(posedge clk);
    chk({31'h0, irq}, 32'h0);
    wr(32'h0, 32'h100);
    repeat (3) @(posedge clk);
    chk({31'h0, irq}, 32'h1);
    wr(32'hc, 32'h1);
    repeat (3) @(posedge clk);
    chk({31'h0, irq}, 32'h0);
    // reload on a rising pin edge
    wr(32'h8, 32'h1000);
    wr(32'h4, 32'h0);
    wr(32'h0, 32'h139);
    i_pin.drive(1'b1, $urandom % 4);
    repeat (8) @(posedge clk);
    wr(32'h0, 32'h100);
    rd(32'h4);
    rng(q, 32'h1000, 32'h1018);
    rd(32'hc);
    chk(q, 32'h1);
    wr(32'hc, 32'h1);
    // up/down: pin low counts down, underflow reloads all ones
    wr(32'h8, 32'h10);
    wr(32'h4, 32'h20);
    i_pin.drive(1'b0, 0);
    repeat (4) @(posedge clk);
    wr(32'h0, 32'h125);
    repeat (40) @(posedge clk);
    wr(32'h0, 32'h104);
    rd(32'h4);
    rng(q, 32'hffc0, 32'hfffe);
    // pin high counts up, overflow reloads the programmed value
    wr(32'h4, 32'hfff8);
    i_pin.drive(1'b1, 0);
    repeat (4) @(posedge clk);
    wr(32'h0, 32'h125);
    repeat (20) @(posedge clk);
    wr(32'h0, 32'h104);
    rd(32'h4);
    rng(q, 32'h10, 32'h30);
    rd(32'hc);
    chk(q, 32'h0);
    chk({31'h0, irq}, 32'h0);
    // capture on a falling edge from a random start
    s = $urandom_range(32'h8000, 32'h100);
    wr(32'h8, 32'h5555);
    wr(32'h4, s);
    wr(32'h0, 32'h227);
    i_pin.drive(1'b0, $urandom % 4);
    repeat (6) @(posedge clk);
    wr(32'h0, 32'h200);
    rd(32'h8);
    rng(q, s, s + 30);
    rd(32'hc);
    chk(q, 32'h2);
    chk({31'h0, irq}, 32'h1);
    wr(32'hc, 32'h2);
    // capture-mode overflow restarts at zero, not at the held value
    wr(32'h4, 32'hfff0);
    wr(32'h0, 32'h123);
    repeat (30) @(posedge clk);
    wr(32'h0, 32'h100);
    rd(32'h4);
    rng(q, 0, 40);
    rd(32'hc);
    chk(q, 32'h1);
    // clock enable low freezes the count
    wr(32'h4, 32'h100);
    wr(32'h0, 32'h21);
    ce <= 1'b0;
    repeat (20) @(posedge clk);
    ce <= 1'b1;
    wr(32'h0, 32'h20);
    rd(32'h4);
    rng(q, 32'h100, 32'h108);
    end_of_test;
  end
endmodule
